// >>> rtl/asq_top.sv
// acquisition store qualifier: trigger sequencer, storage qualification and delay stop
// assumes sut_valid marks one sampled bus cycle of the system under test per pulse,
// and that the acquisition memory outside writes acq_data at acq_addr on acq_we
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "asq_regs.svh"

module asq_top (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic                    avs_waitrequest,
	output logic [31:0]             avs_readdata,
	input  wire logic               sut_valid,
	input  wire asq_pkg::asq_word_t sut_word,
	output logic                    acq_we,
	output asq_pkg::asq_ptr_t       acq_addr,
	output asq_pkg::asq_acq_t       acq_data,
	output logic                    acq_trig,
	output logic                    trig_out,
	output logic                    run_out
);
	import asq_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic              wait_reg, wait_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [31:0]       rd_cur, wm;
	logic              commit, start_p, stop_p;
	logic [31:0]       ctrl_reg, ctrl_next;
	asq_cnt_t          lim_reg [2];
	asq_cnt_t          lim_next [2];
	asq_word_t         mval_reg [`ASQ_NMATCH];
	asq_word_t         mval_next [`ASQ_NMATCH];
	asq_word_t         mcare_reg [`ASQ_NMATCH];
	asq_word_t         mcare_next [`ASQ_NMATCH];
	asq_branch_t       br_reg [`ASQ_NBRREG];
	asq_branch_t       br_next [`ASQ_NBRREG];
	asq_run_t          run_reg, run_next;
	logic [1:0]        seq_reg, seq_next;
	asq_ptr_t          ptr_reg, ptr_next;
	asq_ptr_t          tloc_reg, tloc_next;
	asq_cnt_t          dly_reg, dly_next;
	logic              we_reg, we_next;
	asq_ptr_t          addr_reg, addr_next;
	asq_acq_t          data_reg, data_next;
	logic              mark_reg, mark_next;
	logic              tout_reg, tout_next;
	logic              runo_reg, runo_next;
	logic [`ASQ_NMATCH-1:0] hit;
	logic [1:0]        reached;
	logic [7:0]        srcs;
	logic              qual_any, blk_hit, active, store, fire;
	logic              c_qual, c_trig, c_jmp, any_ev;
	logic [1:0]        c_inc, c_tgt;
	asq_cnt_t          dly_target;

	// byte-lane merge of write data into the current value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// avalon slave handshake
	// ----------------------------------------------------------------
	// one wait cycle per access; read data is latched while waitrequest is still high, write data commits once it is low
	assign commit = avs_write & ~wait_reg;

	always_comb begin
		wait_next  = ~((avs_read | avs_write) & wait_reg);
		rdata_next = rdata_reg;
		if ((avs_read | avs_write) && wait_reg) begin
			rdata_next = avs_read ? rd_cur : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wait_reg  <= 1'b1;
			rdata_reg <= `ASQ_RST_WORD;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// register read mux, unmapped offsets read zero
	// ----------------------------------------------------------------
	always_comb begin
		rd_cur = 32'h0000_0000;
		if (avs_address == `ASQ_OFF_CTRL) begin
			rd_cur = ctrl_reg;
		end else if (avs_address == `ASQ_OFF_STATUS) begin
			rd_cur = {dly_reg, 12'h000, seq_reg, run_reg};
		end else if (avs_address == `ASQ_OFF_PTR) begin
			rd_cur = {16'h0000, tloc_reg, ptr_reg};
		end else if (avs_address == `ASQ_OFF_LIM0) begin
			rd_cur = {16'h0000, lim_reg[0]};
		end else if (avs_address == `ASQ_OFF_LIM1) begin
			rd_cur = {16'h0000, lim_reg[1]};
		end else if (avs_address[7:5] == `ASQ_MATCH_REGION) begin
			rd_cur = avs_address[2] ? {1'b0, mcare_reg[avs_address[4:3]]}
			                        : {1'b0, mval_reg[avs_address[4:3]]};
		end else if (avs_address[7:6] == `ASQ_BR_REGION && avs_address[5:2] < `ASQ_NBRREG) begin
			rd_cur = {21'h000000, br_reg[avs_address[5:2]]};
		end
	end

	// ----------------------------------------------------------------
	// program registers
	// ----------------------------------------------------------------
	// start and stop are write pulses; they are never stored
	always_comb begin
		ctrl_next  = ctrl_reg;
		lim_next   = lim_reg;
		mval_next  = mval_reg;
		mcare_next = mcare_reg;
		br_next    = br_reg;
		start_p    = 1'b0;
		stop_p     = 1'b0;
		wm         = merge(rd_cur, avs_writedata, avs_byteenable);
		if (commit) begin
			if (avs_address == `ASQ_OFF_CTRL) begin
				ctrl_next = wm;
				ctrl_next[`ASQ_CTRL_START] = 1'b0;
				ctrl_next[`ASQ_CTRL_STOP]  = 1'b0;
				start_p = wm[`ASQ_CTRL_START];
				stop_p  = wm[`ASQ_CTRL_STOP];
			end else if (avs_address == `ASQ_OFF_LIM0) begin
				lim_next[0] = wm[15:0];
			end else if (avs_address == `ASQ_OFF_LIM1) begin
				lim_next[1] = wm[15:0];
			end else if (avs_address[7:5] == `ASQ_MATCH_REGION) begin
				if (avs_address[2]) begin
					mcare_next[avs_address[4:3]] = wm[30:0];
				end else begin
					mval_next[avs_address[4:3]] = wm[30:0];
				end
			end else if (avs_address[7:6] == `ASQ_BR_REGION && avs_address[5:2] < `ASQ_NBRREG) begin
				br_next[avs_address[5:2]] = asq_branch_t'(wm[10:0]);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg   <= `ASQ_RST_WORD;
			lim_reg    <= '{default: '0};
			mval_reg   <= '{default: '0};
			mcare_reg  <= '{default: '0};
			br_reg     <= '{default: '0};
		end else begin
			ctrl_reg   <= ctrl_next;
			lim_reg    <= lim_next;
			mval_reg   <= mval_next;
			mcare_reg  <= mcare_next;
			br_reg     <= br_next;
		end
	end

	// ----------------------------------------------------------------
	// event sources: pattern matchers and counters
	// ----------------------------------------------------------------
	for (genvar g = 0; g < `ASQ_NMATCH; g++) begin : g_match
		asq_matcher u_match (
			.clk_unused_n (1'b0),
			.word         (sut_word),
			.value        (mval_reg[g]),
			.care         (mcare_reg[g]),
			.hit          (hit[g])
		);
	end

	for (genvar g = 0; g < 2; g++) begin : g_cnt
		asq_counter u_cnt (
			.mclk    (mclk),
			.rst_n   (rst_n),
			.clr     (start_p),
			.inc     (active & c_inc[g]),
			.limit   (lim_reg[g]),
			.reached (reached[g])
		);
	end

	// sources 0-3 matchers, 4-5 counter conditions, 6-7 never true
	assign srcs = {2'b00, reached, hit};

	// ----------------------------------------------------------------
	// branch evaluation of the active state
	// ----------------------------------------------------------------
	// true event branches merge store, trigger and count commands, the first jump wins; the fallback runs only when none is true
	always_comb begin
		asq_branch_t br;
		logic        take;
		br     = '0;
		take   = 1'b0;
		c_qual = 1'b0;
		c_trig = 1'b0;
		c_jmp  = 1'b0;
		c_inc  = 2'b00;
		c_tgt  = seq_reg;
		any_ev = 1'b0;
		for (int b = 0; b < `ASQ_NBR; b++) begin
			br = br_reg[4'(seq_reg) * 4'(`ASQ_NBR) + 4'(b)];
			if (b == `ASQ_NBR - 1) begin
				take = ~any_ev;
			end else begin
				take = srcs[br.src] ^ br.inv;
				any_ev = any_ev | take;
			end
			if (take) begin
				c_qual = c_qual | br.qual;
				c_trig = c_trig | br.trig;
				if (br.inc_en) begin
					c_inc[br.inc_sel] = 1'b1;
				end
				if (br.jump && !c_jmp) begin
					c_jmp = 1'b1;
					c_tgt = br.target;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// storage qualification
	// ----------------------------------------------------------------
	// any store command anywhere switches the whole run to qualified storage
	always_comb begin
		qual_any = ctrl_reg[`ASQ_CTRL_BLK_EN];
		for (int i = 0; i < `ASQ_NBRREG; i++) begin
			qual_any = qual_any | br_reg[i].qual;
		end
		blk_hit = ctrl_reg[`ASQ_CTRL_BLK_EN]
		        & (srcs[ctrl_reg[`ASQ_CTRL_BLK_SRC]] ^ ctrl_reg[`ASQ_CTRL_BLK_INV]);
		active  = sut_valid & (run_reg == ASQ_PRE || run_reg == ASQ_POST);
		store   = active & (qual_any ? (blk_hit | c_qual) : 1'b1);
		fire    = active & c_trig & (run_reg == ASQ_PRE);
		dly_target = ctrl_reg[`ASQ_CTRL_MID] ? `ASQ_MID_DELAY : ctrl_reg[`ASQ_CTRL_DELAY];
	end

	// ----------------------------------------------------------------
	// run sequencer and acquisition write port
	// ----------------------------------------------------------------
	always_comb begin
		run_next  = run_reg;
		seq_next  = seq_reg;
		ptr_next  = ptr_reg;
		tloc_next = tloc_reg;
		dly_next  = dly_reg;
		we_next   = 1'b0;
		addr_next = addr_reg;
		data_next = data_reg;
		mark_next = 1'b0;
		tout_next = 1'b0;
		if (start_p) begin
			run_next  = ASQ_PRE;
			seq_next  = 2'b00;
			ptr_next  = '0;
			tloc_next = '0;
			dly_next  = '0;
		end else if (stop_p && run_reg != ASQ_IDLE) begin
			run_next = ASQ_DONE;
		end else if (active) begin
			if (c_jmp) begin
				seq_next = c_tgt;
			end
			if (store) begin
				we_next   = 1'b1;
				addr_next = ptr_reg;
				data_next = sut_word[27:0];
				mark_next = fire;
				ptr_next  = ptr_reg + 8'h01;
			end
			if (fire) begin
				run_next  = (dly_target == '0) ? ASQ_DONE : ASQ_POST;
				tloc_next = ptr_reg;
				tout_next = 1'b1;
			end else if (run_reg == ASQ_POST && store) begin
				dly_next = dly_reg + 16'h0001;
				if (dly_reg + 16'h0001 == dly_target) begin
					run_next = ASQ_DONE;
				end
			end
		end
		runo_next = (run_next == ASQ_PRE || run_next == ASQ_POST);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_reg  <= ASQ_IDLE;
			seq_reg  <= 2'b00;
			ptr_reg  <= '0;
			tloc_reg <= '0;
			dly_reg  <= '0;
			we_reg   <= 1'b0;
			addr_reg <= '0;
			data_reg <= '0;
			mark_reg <= 1'b0;
			tout_reg <= 1'b0;
			runo_reg <= 1'b0;
		end else begin
			run_reg  <= run_next;
			seq_reg  <= seq_next;
			ptr_reg  <= ptr_next;
			tloc_reg <= tloc_next;
			dly_reg  <= dly_next;
			we_reg   <= we_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			mark_reg <= mark_next;
			tout_reg <= tout_next;
			runo_reg <= runo_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign acq_we          = we_reg;
	assign acq_addr        = addr_reg;
	assign acq_data        = data_reg;
	assign acq_trig        = mark_reg;
	assign trig_out        = tout_reg;
	assign run_out         = runo_reg;

endmodule

`default_nettype wire

// >>> inc/asq_regs.svh
// register offsets, field positions and timing counts of the store qualifier
// assumes a 32-bit avalon-mm slave with byte addresses on an 8-bit address port
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASQ_OFF_CTRL      8'h00
`define ASQ_OFF_STATUS    8'h04
`define ASQ_OFF_PTR       8'h08
`define ASQ_OFF_LIM0      8'h10
`define ASQ_OFF_LIM1      8'h14
`define ASQ_MATCH_REGION  3'h1
`define ASQ_BR_REGION     2'h1
`define ASQ_NBRREG        4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASQ_CTRL_START    0
`define ASQ_CTRL_STOP     1
`define ASQ_CTRL_MID      2
`define ASQ_CTRL_BLK_EN   3
`define ASQ_CTRL_BLK_SRC  6:4
`define ASQ_CTRL_BLK_INV  7
`define ASQ_CTRL_DELAY    31:16
`define ASQ_RW_BIT        24

// ----------------------------------------------------------------
// sizes, counts and reset values
// ----------------------------------------------------------------
`define ASQ_NSTATE        4
`define ASQ_NEV           2
`define ASQ_NBR           3
`define ASQ_NMATCH        4
`define ASQ_MID_DELAY     16'h007f
`define ASQ_CNT_MAX       16'hfffe
`define ASQ_RST_WORD      32'h0000_0000

`endif

// >>> inc/asq_pkg.sv
// types shared by the store qualifier modules
// assumes asq_regs.svh supplies offsets and field positions
package asq_pkg;

	// sampled bus word: addr 15:0, data 23:16, control 30:24
	typedef logic [30:0] asq_word_t;
	typedef logic [27:0] asq_acq_t;
	typedef logic [7:0]  asq_ptr_t;
	typedef logic [15:0] asq_cnt_t;

	// acquisition run phases
	typedef enum logic [1:0] {
		ASQ_IDLE = 2'b00,
		ASQ_PRE  = 2'b01,
		ASQ_POST = 2'b10,
		ASQ_DONE = 2'b11
	} asq_run_t;

	// one event branch of a sequencer state
	typedef struct packed {
		logic [1:0] target;
		logic       jump;
		logic       trig;
		logic       inc_sel;
		logic       inc_en;
		logic       qual;
		logic       inv;
		logic [2:0] src;
	} asq_branch_t;

endpackage

// >>> rtl/asq_matcher.sv
// bus pattern matcher: compares the sampled word against value under a care mask
// assumes the word is stable for the cycle in which it is evaluated
`timescale 1ns/100ps
`default_nettype none

module asq_matcher (
	input  wire logic               clk_unused_n,
	input  wire asq_pkg::asq_word_t word,
	input  wire asq_pkg::asq_word_t value,
	input  wire asq_pkg::asq_word_t care,
	output logic                    hit
);
	import asq_pkg::*;

	// plain equality on cared bits; r/w bit 0 equals a write cycle
	assign hit = ((word ^ value) & care) == '0;

endmodule

`default_nettype wire

// >>> rtl/asq_counter.sv
// event counter with a programmed limit, saturating at its top value
// assumes clear and increment come from the sequencer in the mclk domain
`timescale 1ns/100ps
`default_nettype none
`include "asq_regs.svh"

module asq_counter (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              clr,
	input  wire logic              inc,
	input  wire asq_pkg::asq_cnt_t limit,
	output logic                   reached
);
	import asq_pkg::*;

	asq_cnt_t count_reg;
	asq_cnt_t count_next;

	// condition is true only while the count equals the limit
	assign reached = (count_reg == limit);

	// saturate rather than wrap so a reached limit cannot silently re-arm
	always_comb begin
		count_next = count_reg;
		if (clr) begin
			count_next = '0;
		end else if (inc && count_reg != `ASQ_CNT_MAX) begin
			count_next = count_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule

`default_nettype wire

// >>> verif/asq_sut_model.sv
// far-side model: sampled bus cycles of the probed processor
// assumes en and slow change by non-blocking assignment after a rising edge
`timescale 1ns/100ps
`default_nettype none

module asq_sut_model (
	input  wire logic         mclk,
	input  wire logic         en,
	input  wire logic         slow,
	output logic              sut_valid,
	output asq_pkg::asq_word_t sut_word
);
	import asq_pkg::*;

	// only addr[1:0], data[17:16] and r/w vary, so the matchers hit often
	localparam asq_word_t VARY = 31'h0103_0003;

	initial begin
		sut_valid = 1'b0;
		sut_word = '0;
	end

	// slow mode leaves gaps between bus cycles
	always @(posedge mclk) begin
		if (en && (!slow || $urandom_range(2) == 0)) begin
			sut_valid <= 1'b1;
			sut_word <= asq_word_t'($urandom) & VARY;
		end else begin
			sut_valid <= 1'b0;
			sut_word <= ~sut_word; // no valid cycle: never the last word
		end
	end
endmodule
`default_nettype wire

// >>> verif/asq_top_sva.sv
// checker of the store qualifier ports: store, trigger and bus timing
// assumes it is bound to asq_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module asq_top_sva (
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire logic [7:0]         avs_address,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_writedata,
	input wire logic [3:0]         avs_byteenable,
	input wire logic               avs_waitrequest,
	input wire logic [31:0]        avs_readdata,
	input wire logic               sut_valid,
	input wire asq_pkg::asq_word_t sut_word,
	input wire logic               acq_we,
	input wire asq_pkg::asq_ptr_t  acq_addr,
	input wire asq_pkg::asq_acq_t  acq_data,
	input wire logic               acq_trig,
	input wire logic               trig_out,
	input wire logic               run_out
);
	import asq_pkg::*;
	logic [27:0] word_next;
	logic [27:0] word_reg;

	// ----------------------------------------------------------------
	// last sampled word, so stored data can be tied to its cause
	// ----------------------------------------------------------------
	always_comb word_next = sut_word[27:0];
	always_ff @(posedge mclk) word_reg <= word_next;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	store_cause_a: assert property (acq_we |-> $past(sut_valid))
		else $error("store without a sampled cycle");
	store_data_a: assert property (acq_we |-> acq_data == word_reg)
		else $error("stored data is not the sampled word");
	addr_step_a: assert property (acq_we && $past(acq_we) |-> acq_addr == $past(acq_addr) + 8'h01)
		else $error("store location did not advance by one");
	trig_mark_a: assert property (acq_trig |-> acq_we && trig_out)
		else $error("trigger mark without store and trigger");
	trig_stored_a: assert property (trig_out && acq_we |-> acq_trig)
		else $error("stored trigger cycle not marked");
	trig_cause_a: assert property (trig_out |-> $past(sut_valid) && $past(run_out))
		else $error("trigger without a sample while running");
	run_end_a: assert property ($fell(run_out) |=> !acq_we ##1 !acq_we)
		else $error("store after acquisition ended");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	unmapped_zero_a: assert property (!avs_waitrequest && $past(avs_read) && $past(avs_address) == 8'h70
		|-> avs_readdata == 32'h0)
		else $error("unmapped offset read nonzero");

	trig_kept_c: cover property (acq_trig);
	trig_dropped_c: cover property (trig_out && !acq_we);
	run_over_c: cover property ($fell(run_out));
endmodule

bind asq_top asq_top_sva u_asq_top_sva (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .avs_readdata, .sut_valid, .sut_word, .acq_we, .acq_addr, .acq_data,
	.acq_trig, .trig_out, .run_out);
`default_nettype wire

// >>> verif/test_acquisition_store_qualifier.sv
// testbench of the store qualifier: programs runs and compares each store
// assumes asq_sut_model drives the probed bus and the checker is bound
`timescale 1ns/100ps
`default_nettype none
`include "asq_regs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module test_acquisition_store_qualifier;
	import asq_pkg::*;
	localparam logic [10:0] NV = 11'h006; // branch whose event never fires
	logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, en = 0, slow = 0;
	logic [7:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, ctl, rd;
	logic [3:0]  avs_byteenable = 4'hf;
	logic        avs_waitrequest, sut_valid, acq_we, acq_trig, trig_out, run_out;
	asq_word_t   sut_word;
	asq_ptr_t    acq_addr;
	asq_acq_t    acq_data;
	logic [30:0] mval[4], mcare[4];
	logic [10:0] brg[12], b;
	logic [36:0] exq[$], e;
	int          bad_count, comparisons, ph, st, nst, dly, ptr, tloc, ntrig, nseen, cnt[2], lim[2];
	bit          any, sto, tr, jd, qm;
	logic [1:0]  inc;

	always #12.5 mclk = ~mclk;

	asq_top u_asq_top (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_waitrequest, .avs_readdata, .sut_valid, .sut_word, .acq_we, .acq_addr, .acq_data, .acq_trig,
		.trig_out, .run_out);
	asq_sut_model u_asq_sut_model (.mclk, .en, .slow, .sut_valid, .sut_word);

	task summarize;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [10:0] mk(int s, bit i, bit q, bit c, bit cs, bit t, bit j, int tg);
		return {tg[1:0], j, t, cs, c, q, i, s[2:0]};
	endfunction

	function automatic bit ev(logic [2:0] s, bit i, asq_word_t w);
		bit r;
		r = s < 4 ? (((w ^ mval[s]) & mcare[s]) == 0) : s < 6 ? cnt[s - 4] == lim[s - 4] : 0;
		return r ^ i; // complement acts on this one event only
	endfunction

	// ----------------------------------------------------------------
	// bus master, shadowing every write into the reference model
	// ----------------------------------------------------------------
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		n = 0;
		do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n == 20) begin bad_count++; summarize(); end
		if (w && a == 0) begin
			ctl = d & ~32'h3;
			if (d[0]) begin cnt = '{0, 0}; ptr = 0; tloc = 0; dly = 0; st = 0; ph = 1; end
			if (d[1] && ph != 0) ph = 3;
		end
		if (w && a >= 8'h10 && a < 8'h18) lim[a[2]] = d[15:0];
		if (w && a >= 8'h20 && a < 8'h40 && a[2]) mcare[a[4:3]] = d[30:0];
		if (w && a >= 8'h20 && a < 8'h40 && !a[2]) mval[a[4:3]] = d[30:0];
		if (w && a >= 8'h40 && a < 8'h70) brg[(a - 8'h40) >> 2] = d[10:0];
	endtask

	task prog(input logic [10:0] p[12]);
		for (int k = 0; k < 12; k++) bus(1, 8'h40 + 8'(4 * k), {21'h0, p[k]});
	endtask

	task wait_run(input logic v, input int lim);
		int n;
		n = 0;
		while (run_out !== v && n < lim) begin @(posedge mclk); n++; end
		if (n == lim) begin bad_count++; $display("[FAIL] run_out expected %0h seen %0h", v, run_out); summarize(); end
	endtask

	task run(input logic [31:0] c, input logic s, input int d);
		bus(1, `ASQ_OFF_CTRL, c | 32'h1);
		en <= 1;
		slow <= s;
		wait_run(1, 10);
		wait_run(0, 4000);
		en <= 0;
		repeat (3) @(posedge mclk);
		bus(0, `ASQ_OFF_STATUS, 0);
		`CHK("run", 2'd3, rd[1:0])
		`CHK("delay", d[15:0], rd[31:16])
		bus(0, `ASQ_OFF_PTR, 0);
		`CHK("ptr", {tloc[7:0], ptr[7:0]}, rd[15:0])
		`CHK("left", 0, exq.size())
		`CHK("triggers", ntrig, nseen)
	endtask

	// ----------------------------------------------------------------
	// reference sequencer, evaluated on the same edge as the design
	// ----------------------------------------------------------------
	always @(posedge mclk) if (sut_valid === 1'b1 && (ph == 1 || ph == 2)) begin
		any = 0; sto = 0; tr = 0; jd = 0; inc = 0; nst = st;
		qm = ctl[3];
		for (int k = 0; k < 12; k++) qm |= brg[k][4];
		for (int k = 0; k < 3; k++) begin
			b = brg[st * 3 + k];
			if (k < 2 ? ev(b[2:0], b[3], sut_word) : !any) begin
				any = 1;
				sto |= b[4];
				tr |= b[7];
				if (b[5]) inc[b[6]] = 1;
				if (b[8] && !jd) begin nst = b[10:9]; jd = 1; end
			end
		end
		if (ctl[3] && ev(ctl[6:4], ctl[7], sut_word)) sto = 1;
		if (!qm) sto = 1;
		tr = tr && ph == 1;
		if (tr) tloc = ptr; // trigger location is kept even when the cycle is not stored
		if (sto) begin
			exq.push_back({ptr[7:0], sut_word[27:0], tr});
			ptr = (ptr + 1) % 256;
			if (ph == 2) dly++;
		end
		for (int k = 0; k < 2; k++) if (inc[k] && cnt[k] < 16'hfffe) cnt[k]++;
		if (tr) begin ph = 2; ntrig++; end
		if (ph == 2 && dly == (ctl[2] ? 127 : int'(ctl[31:16]))) ph = 3;
		st = nst;
	end

	// design stores against the reference queue
	always @(posedge mclk) begin
		if (trig_out === 1'b1) nseen++;
		if (acq_we === 1'b1) begin
			e = exq.size() ? exq.pop_front() : '1;
			`CHK("acq_addr", e[36:29], acq_addr)
			`CHK("acq_data", e[28:1], acq_data)
			`CHK("acq_trig", e[0], acq_trig)
		end
	end

	initial begin
		void'($urandom(32'h2e62b1f8));
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		// reset values and an unmapped offset
		bus(0, `ASQ_OFF_STATUS, 0);
		`CHK("status", 32'h0, rd)
		bus(0, `ASQ_OFF_PTR, 0);
		`CHK("ptr", 32'h0, rd)
		bus(1, 8'h70, 32'hffff_ffff);
		bus(0, 8'h70, 0);
		`CHK("unmapped", 32'h0, rd)
		bus(1, `ASQ_OFF_LIM1, 32'h0000_1234);
		bus(0, `ASQ_OFF_LIM1, 0);
		`CHK("lim1", 32'h0000_1234, rd)
		// byte lane 1 only: the low byte of the limit must survive
		avs_byteenable <= 4'h2;
		bus(1, `ASQ_OFF_LIM1, 32'hffff_ab00);
		avs_byteenable <= 4'hf;
		bus(0, `ASQ_OFF_LIM1, 0);
		`CHK("lim1 lane", 32'h0000_ab34, rd)
		// matchers: writes, addr 1, data bit 16, addr 2
		bus(1, 8'h20, 0);
		bus(1, 8'h24, 32'h0100_0000);
		bus(1, 8'h28, 1);
		bus(1, 8'h2c, 3);
		bus(1, 8'h30, 32'h0001_0000);
		bus(1, 8'h34, 32'h0001_0000);
		bus(1, 8'h38, 2);
		bus(1, 8'h3c, 3);
		bus(1, `ASQ_OFF_LIM0, 3);
		// count writes, trigger on the limit, then ping-pong states storing all
		prog('{mk(0, 0, 1, 1, 0, 0, 0, 0), mk(4, 0, 1, 0, 0, 1, 1, 1), NV, mk(1, 0, 1, 0, 0, 0, 1, 2), NV,
			mk(6, 0, 1, 0, 0, 0, 0, 0), NV, NV, mk(6, 0, 1, 0, 0, 0, 1, 1), NV, NV, NV});
		run(32'h0000_0004, 0, 127);
		// inverted block qualifier with commands, trigger branch without a store command
		prog('{mk(1, 0, 1, 0, 0, 0, 0, 0), mk(3, 0, 0, 0, 0, 1, 1, 3), NV, NV, NV, NV, NV, NV, NV, NV, NV, NV});
		run(32'h0005_00a8, 1, 5);
		// no stores after the trigger: runs until stopped
		prog('{mk(0, 0, 1, 0, 0, 1, 1, 3), NV, NV, NV, NV, NV, NV, NV, NV, NV, NV, NV});
		bus(1, `ASQ_OFF_CTRL, 32'h0004_0001);
		en <= 1;
		wait_run(1, 10);
		repeat (300) @(posedge mclk);
		bus(0, `ASQ_OFF_STATUS, 0);
		`CHK("post run", 2'd2, rd[1:0])
		en <= 0;
		bus(1, `ASQ_OFF_CTRL, 32'h0004_0002);
		wait_run(0, 20);
		bus(0, `ASQ_OFF_STATUS, 0);
		`CHK("stopped", 2'd3, rd[1:0])
		`CHK("triggers", ntrig, nseen)
		summarize();
	end
endmodule
`default_nettype wire
